// ---- core/rem_pkg.sv ----
// Constants and types shared by the event, meter and command block
package rem_pkg;
  // Register byte offsets
  localparam logic [5:0] REG_CMD = 6'h00;
  localparam logic [5:0] REG_DATA = 6'h04;
  localparam logic [5:0] REG_CFG = 6'h08;
  localparam logic [5:0] REG_STAT = 6'h0c;
  localparam logic [5:0] REG_DATE = 6'h10;
  localparam logic [5:0] REG_TIME = 6'h14;
  localparam logic [5:0] REG_HSEL = 6'h18;
  localparam logic [5:0] REG_HINFO = 6'h1c;
  localparam logic [5:0] REG_HSTAMP = 6'h20;
  localparam logic [5:0] REG_QSEL = 6'h24;
  localparam logic [5:0] REG_DEM = 6'h28;
  localparam logic [5:0] REG_PEAK = 6'h2c;
  // Event store geometry: 11 cycles of 4 rows, trigger on row 16
  localparam int SLOTS = 12;
  localparam int PHYS = 13;
  localparam int ROWS = 44;
  localparam int PRE = 15;
  localparam logic [5:0] POST = 6'h1c;
  localparam logic [5:0] EVT_WORDS = 6'h2f;
  localparam logic [5:0] MET_WORDS = 6'h07;
  localparam logic [5:0] ID_WORDS = 6'h03;
  localparam logic [5:0] DATE_WORDS = 6'h01;
  // Flow control and confirmation characters
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] CH_CAN = 8'h18;
  localparam logic [7:0] CH_YES = 8'h59;
  // Year store time and clock
  localparam int CLK_NS = 10;
  localparam int STORE_US = 10;
  localparam logic [11:0] STORE_CYC = 12'(STORE_US * 1000 / CLK_NS);
  // Reset values
  localparam logic [1:0] LEVEL_RST = 2'h0;
  localparam logic [23:0] DATE_RST = 24'h010101;
  // Commands
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_ACCESS = 4'h1, CMD_DATE = 4'h2, CMD_EVENT = 4'h3,
    CMD_TRIGGER = 4'h4, CMD_TSYNC = 4'h5, CMD_METER = 4'h6,
    CMD_DEM_RST = 4'h7, CMD_PEAK_RST = 4'h8, CMD_QUIT = 4'h9
  } rem_cmd_e;
  // Command results
  typedef enum logic [3:0] {
    RES_OK = 4'h0, RES_BAD_EVENT = 4'h1, RES_BAD_CMD = 4'h2,
    RES_BAD_LEVEL = 4'h3, RES_TC_ERROR = 4'h4, RES_BUSY = 4'h5,
    RES_NOT_CONFIRMED = 4'h6
  } rem_res_e;
  // Recorded trigger causes
  typedef enum logic [2:0] {
    CAUSE_NONE = 3'h0, CAUSE_TRIP_VAR = 3'h1, CAUSE_DIRECT = 3'h2,
    CAUSE_OPEN = 3'h3, CAUSE_REPORT_VAR = 3'h4, CAUSE_EXT = 3'h5,
    CAUSE_CMD = 3'h6
  } rem_cause_e;
  // Output stream kinds
  typedef enum logic [1:0] {
    SK_ID = 2'h0, SK_EVT = 2'h1, SK_MET = 2'h2, SK_DATE = 2'h3
  } rem_kind_e;
  // Control states
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_STORE = 2'h1, ST_SEND = 2'h2
  } rem_state_e;
  // Avalon-MM slave request
  typedef struct packed {
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } rem_avs_req_s;
  // Protection inputs sampled by the recorder
  typedef struct packed {
    logic tripping_variable;
    logic direct_trip_input;
    logic open_cmd;
    logic report_trigger_variable;
    logic external_trigger_input;
  } rem_trigger_command_cause_s;
  // Decoded time-code
  typedef struct packed {
    logic present;
    logic ok;
    logic [23:0] date;
    logic [31:0] time_qc;
  } rem_tc_s;
endpackage

// ---- core/rem_core.sv ----
// Event recorder, metering and command interpreter with Avalon-MM registers
`timescale 1ns/1ns
module rem_core #(
  parameter logic [31:0] ID_WORD = 32'h0000_0a5a, // Arbitrary identifier value
  parameter int DEMAND_TIME_CONSTANT = 4,         // Demand filter shift
  parameter int NQ = 7                            // Metered quantities
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire rem_pkg::rem_avs_req_s avs_req,
  output logic avs_waitrequest,
  output logic [31:0] avs_readdata,
  // Terminal stream: report words out, received characters in
  output logic tx_valid,
  output logic [31:0] tx_data,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  // Protection logic and measurements
  input wire rem_pkg::rem_trigger_command_cause_s trigger_command_cause_in,
  input wire logic qc_strobe,
  input wire logic [15:0] sample_row,
  input wire logic signed [NQ-1:0][15:0] meas,
  input wire logic [7:0] fault_targets,
  input wire logic [2:0] active_group,
  input wire logic settings_changed,
  input wire logic group_copied,
  input wire logic power_lost,
  input wire rem_pkg::rem_tc_s tc_in,
  // Nonvolatile year store and contacts
  input wire logic [7:0] nv_year_in,
  output logic nv_year_wr,
  output logic [7:0] nv_year_data,
  output logic alarm_contact,
  output logic front_panel_target_set,
  output logic [1:0] access_level
);
  import rem_pkg::*;

  // Whole control state of the block
  typedef struct packed {
    rem_state_e st;
    logic [1:0] level;
    rem_res_e res;
    logic demand_reset_on_group_change;
    logic [31:0] data;
    logic [23:0] date;
    logic [31:0] time_qc;
    logic [3:0] hsel;
    logic [2:0] qsel;
    rem_kind_e kind;
    logic [5:0] widx;
    logic [7:0] rep;
    logic [3:0] eslot;
    logic paused;
    logic txv;
    logic [31:0] txd;
    logic [11:0] cnt;
    logic alarm;
    logic nvwr;
    logic [3:0] head;
    logic [PHYS-1:0] valid;
    logic rec;
    logic [5:0] wp;
    logic [5:0] post;
    logic [4:0] trigger_command_cause_prev;
    logic [2:0] grp_prev;
    logic tgt;
    logic cmd_trigger_command_cause;
    logic ack;
    logic [31:0] rdata;
    logic pl_s1;
    logic pl_s2;
    logic pl_prev;
    logic [NQ-1:0][15:0] dem;
    logic [NQ-1:0][15:0] peak;
  } rem_state_s;

  rem_state_s s_reg;
  rem_state_s s_next;

  // Event rows and per-slot summaries
  logic [15:0] mem [PHYS*ROWS];
  logic [31:0] h_info [PHYS];
  logic [23:0] h_date [PHYS];
  logic [31:0] h_time [PHYS];
  logic [5:0] h_start [PHYS];

  // Write strobes from the next-state logic
  logic row_we;
  logic hist_we;
  logic [31:0] hist_info;

  // Slot that is n-th newest, n of 0 meaning 1
  function automatic logic [3:0] slot_of(input logic [3:0] head, input logic [3:0] n);
    logic [4:0] k;
    k = (n == 4'h0) ? 5'h1 : {1'b0, n};
    slot_of = 4'((5'(head) + 5'(PHYS) - k) % 5'(PHYS));
  endfunction

  // Row index wrapped into one report
  function automatic logic [5:0] row_wrap(input logic [6:0] r);
    row_wrap = 6'(r % 7'(ROWS));
  endfunction

  // Flat row address
  function automatic logic [9:0] row_addr(input logic [3:0] slot, input logic [5:0] r);
    row_addr = 10'(slot) * 10'(ROWS) + 10'(r);
  endfunction

  // Largest phase current magnitude of the three phases
  function automatic logic [15:0] max_phase(input logic signed [NQ-1:0][15:0] m);
    logic [15:0] a;
    logic [15:0] b;
    // Elements of a packed array are unsigned, so test the sign explicitly
    a = (signed'(m[0]) < 0) ? 16'(-signed'(m[0])) : m[0];
    b = (signed'(m[1]) < 0) ? 16'(-signed'(m[1])) : m[1];
    if (b > a) a = b;
    b = (signed'(m[2]) < 0) ? 16'(-signed'(m[2])) : m[2];
    max_phase = (b > a) ? b : a;
  endfunction

  // Word of the present stream at index w
  function automatic logic [31:0] stream_word(input rem_state_s s, input logic [5:0] w,
    input logic [15:0] row);
    stream_word = 32'h0;
    unique case (s.kind)
      SK_ID: stream_word = (w == 6'h0) ? ID_WORD :
        (w == 6'h1) ? {8'h0, s.date} : s.time_qc;
      SK_EVT: stream_word = (w == 6'h0) ? h_info[s.eslot] :
        (w == 6'h1) ? {8'h0, h_date[s.eslot]} :
        (w == 6'h2) ? h_time[s.eslot] : {16'h0, row};
      SK_MET: stream_word = 32'(signed'(meas[w[2:0]]));
      SK_DATE: stream_word = {8'h0, s.date};
    endcase
  endfunction

  // Stream length by kind
  function automatic logic [5:0] stream_len(input rem_kind_e k);
    unique case (k)
      SK_ID: stream_len = ID_WORDS;
      SK_EVT: stream_len = EVT_WORDS;
      SK_MET: stream_len = MET_WORDS;
      SK_DATE: stream_len = DATE_WORDS;
    endcase
  endfunction

  // Combinational helpers
  logic [4:0] trigger_command_cause_now;
  logic [4:0] rise;
  logic any_trigger_command_cause;
  rem_cause_e cause;
  logic bus_go;
  logic [3:0] ev_slot;
  logic [15:0] ev_row;
  logic ev_clear;

  assign trigger_command_cause_now = {trigger_command_cause_in.tripping_variable, trigger_command_cause_in.direct_trip_input, trigger_command_cause_in.open_cmd,
    trigger_command_cause_in.report_trigger_variable, trigger_command_cause_in.external_trigger_input};
  assign rise = trigger_command_cause_now & ~s_reg.trigger_command_cause_prev;
  assign any_trigger_command_cause = (|rise) | s_reg.cmd_trigger_command_cause;
  assign bus_go = (avs_req.read | avs_req.write) & s_reg.ack;
  assign ev_slot = slot_of(s_reg.head, 4'(s_reg.data[3:0]));
  assign ev_row = mem[row_addr(s_reg.eslot,
    row_wrap(7'(h_start[s_reg.eslot]) + 7'(s_reg.widx) - 7'h3))];
  assign ev_clear = (s_reg.pl_s2 & ~s_reg.pl_prev) | settings_changed | group_copied;

  // Cause in priority order
  always_comb
  begin
    if (rise[4]) cause = CAUSE_TRIP_VAR;
    else if (rise[3]) cause = CAUSE_DIRECT;
    else if (rise[2]) cause = CAUSE_OPEN;
    else if (rise[1]) cause = CAUSE_REPORT_VAR;
    else if (rise[0]) cause = CAUSE_EXT;
    else cause = CAUSE_CMD;
  end

  // Next state
  always_comb
  begin
    logic free;
    logic [15:0] diff;
    free = 1'b0;
    diff = 16'h0;
    s_next = s_reg;
    row_we = 1'b0;
    hist_we = 1'b0;
    hist_info = {2'b0, cause, active_group, fault_targets, max_phase(meas)};
    s_next.trigger_command_cause_prev = trigger_command_cause_now;
    s_next.grp_prev = active_group;
    s_next.cmd_trigger_command_cause = 1'b0;
    s_next.tgt = 1'b0;
    s_next.nvwr = 1'b0;
    s_next.pl_s1 = power_lost;
    s_next.pl_s2 = s_reg.pl_s1;
    s_next.pl_prev = s_reg.pl_s2;
    // Bus handshake: one wait cycle, then answer
    s_next.ack = (avs_req.read | avs_req.write) & ~s_reg.ack;
    // Time of day in quarter cycles
    if (qc_strobe) s_next.time_qc = s_reg.time_qc + 32'h1;
    // Arm recording on a trigger, stamp the next row
    if (any_trigger_command_cause && !s_reg.rec)
    begin
      s_next.rec = 1'b1;
      s_next.post = POST;
      hist_we = 1'b1;
    end
    // Row capture into the scratch slot
    if (qc_strobe)
    begin
      row_we = 1'b1;
      s_next.wp = row_wrap(7'(s_reg.wp) + 7'h1);
      if (s_reg.rec)
      begin
        if (s_reg.post == 6'h0)
        begin
          s_next.rec = 1'b0;
          s_next.valid[s_reg.head] = 1'b1;
          s_next.head = 4'((5'(s_reg.head) + 5'h1) % 5'(PHYS));
          s_next.valid[4'((5'(s_reg.head) + 5'h1) % 5'(PHYS))] = 1'b0;
        end
        else s_next.post = s_reg.post - 6'h1;
      end
    end
    // Clearing drops reports, so REG_HINFO reads 0; REG_HSTAMP still reads the old stamps
    if (ev_clear) s_next.valid = '0;
    // Demand filtering and peak tracking
    for (int i = 0; i < NQ; i++)
    begin
      if (qc_strobe)
      begin
        diff = 16'((signed'(meas[i]) - signed'(s_reg.dem[i])) >>> DEMAND_TIME_CONSTANT);
        s_next.dem[i] = s_reg.dem[i] + diff;
      end
      if (signed'(s_reg.dem[i]) > signed'(s_reg.peak[i])) s_next.peak[i] = s_reg.dem[i];
    end
    if (active_group != s_reg.grp_prev && s_reg.demand_reset_on_group_change)
      s_next.dem = '0;
    if (s_reg.pl_s2 & ~s_reg.pl_prev)
    begin
      s_next.dem = '0;
      s_next.peak = '0;
    end
    // Register reads
    unique case (avs_req.address)
      REG_DATA: s_next.rdata = s_reg.data;
      REG_CFG: s_next.rdata = {31'h0, s_reg.demand_reset_on_group_change};
      REG_STAT: s_next.rdata = {12'h0, 11'(s_reg.valid), s_reg.paused,
        4'(s_reg.res), s_reg.st != ST_IDLE, 1'b0, s_reg.level};
      REG_DATE: s_next.rdata = {8'h0, s_reg.date};
      REG_TIME: s_next.rdata = s_reg.time_qc;
      REG_HSEL: s_next.rdata = {28'h0, s_reg.hsel};
      REG_HINFO: s_next.rdata = s_reg.valid[slot_of(s_reg.head, s_reg.hsel)] ?
        h_info[slot_of(s_reg.head, s_reg.hsel)] : 32'h0;
      REG_HSTAMP: s_next.rdata = h_time[slot_of(s_reg.head, s_reg.hsel)];
      REG_QSEL: s_next.rdata = {29'h0, s_reg.qsel};
      REG_DEM: s_next.rdata = 32'(signed'(s_reg.dem[s_reg.qsel]));
      REG_PEAK: s_next.rdata = 32'(signed'(s_reg.peak[s_reg.qsel]));
      default: s_next.rdata = 32'h0;
    endcase
    // Register writes and commands
    if (bus_go && avs_req.write)
    begin
      unique case (avs_req.address)
        REG_DATA: s_next.data = avs_req.writedata;
        REG_CFG: s_next.demand_reset_on_group_change = avs_req.writedata[0];
        REG_HSEL: s_next.hsel = avs_req.writedata[3:0];
        REG_QSEL: s_next.qsel = avs_req.writedata[2:0];
        REG_CMD:
        begin
          s_next.res = RES_OK;
          if (s_reg.st != ST_IDLE) s_next.res = RES_BUSY;
          else if (avs_req.writedata[3:0] > 4'(CMD_QUIT) || avs_req.writedata[3:0] == 4'h0)
            s_next.res = RES_BAD_CMD;
          else if (s_reg.level == 2'h0 && avs_req.writedata[3:0] != 4'(CMD_ACCESS))
            s_next.res = RES_BAD_LEVEL;
          else
          begin
            s_next.widx = 6'h0;
            s_next.rep = 8'h1;
            s_next.paused = 1'b0;
            unique case (rem_cmd_e'(avs_req.writedata[3:0]))
              CMD_ACCESS: if (s_reg.level == 2'h0) s_next.level = 2'h1;
              CMD_DATE:
              begin
                s_next.date = s_reg.data[23:0];
                s_next.kind = SK_DATE;
                if (s_reg.data[23:16] != nv_year_in)
                begin
                  s_next.st = ST_STORE;
                  s_next.cnt = STORE_CYC;
                  s_next.alarm = 1'b1;
                  s_next.nvwr = 1'b1;
                end
                else s_next.st = ST_SEND;
              end
              CMD_EVENT:
              begin
                if (s_reg.data[3:0] > 4'(SLOTS) || !s_reg.valid[ev_slot])
                  s_next.res = RES_BAD_EVENT;
                else
                begin
                  s_next.eslot = ev_slot;
                  s_next.kind = SK_EVT;
                  s_next.st = ST_SEND;
                end
              end
              CMD_TRIGGER: s_next.cmd_trigger_command_cause = 1'b1;
              CMD_TSYNC:
              begin
                if (tc_in.present && tc_in.ok)
                begin
                  s_next.date = tc_in.date;
                  s_next.time_qc = tc_in.time_qc;
                  s_next.kind = SK_ID;
                  s_next.st = ST_SEND;
                end
                else s_next.res = RES_TC_ERROR;
              end
              CMD_METER:
              begin
                s_next.kind = SK_MET;
                s_next.st = ST_SEND;
                if (avs_req.writedata[11:4] != 8'h0) s_next.rep = avs_req.writedata[11:4];
              end
              CMD_DEM_RST:
                if (avs_req.writedata[11:4] == CH_YES) s_next.dem = '0;
                else s_next.res = RES_NOT_CONFIRMED;
              CMD_PEAK_RST:
                if (avs_req.writedata[11:4] == CH_YES) s_next.peak = s_reg.dem;
                else s_next.res = RES_NOT_CONFIRMED;
              CMD_QUIT:
              begin
                s_next.level = 2'h0;
                s_next.tgt = 1'b1;
                s_next.kind = SK_ID;
                s_next.st = ST_SEND;
              end
              default: s_next.res = RES_BAD_CMD;
            endcase
          end
        end
        default: ;
      endcase
    end
    // Sequencer
    unique case (s_reg.st)
      ST_IDLE: ;
      // Hold alarm while the year is written, then echo the date
      ST_STORE:
      begin
        s_next.cnt = s_reg.cnt - 12'h1;
        if (s_reg.cnt == 12'h1)
        begin
          s_next.alarm = 1'b0;
          s_next.st = ST_SEND;
        end
      end
      // Feed words to the terminal under flow control
      ST_SEND:
      begin
        if (rx_valid && rx_char == CH_XOFF) s_next.paused = 1'b1;
        if (rx_valid && rx_char == CH_XON) s_next.paused = 1'b0;
        free = !s_reg.txv || tx_ready;
        if (free) s_next.txv = 1'b0;
        if (rx_valid && rx_char == CH_CAN)
        begin
          s_next.txv = 1'b0;
          s_next.st = ST_IDLE;
        end
        else if (free && !s_reg.paused)
        begin
          if (s_reg.widx < stream_len(s_reg.kind))
          begin
            s_next.txd = stream_word(s_reg, s_reg.widx, ev_row);
            s_next.txv = 1'b1;
            s_next.widx = s_reg.widx + 6'h1;
          end
          else if (s_reg.rep > 8'h1)
          begin
            s_next.rep = s_reg.rep - 8'h1;
            s_next.widx = 6'h0;
          end
          else s_next.st = ST_IDLE;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.level <= LEVEL_RST;
      s_reg.res <= RES_OK;
      s_reg.kind <= SK_ID;
      s_reg.date <= DATE_RST;
      s_reg.hsel <= 4'h1;
    end
    else s_reg <= s_next;
  end

  // Event memory and summaries, no reset needed
  always_ff @(posedge clk)
  begin
    if (row_we) mem[row_addr(s_reg.head, s_reg.wp)] <= sample_row;
    if (hist_we)
    begin
      h_info[s_reg.head] <= hist_info;
      h_date[s_reg.head] <= s_reg.date;
      h_time[s_reg.head] <= s_reg.time_qc;
      h_start[s_reg.head] <= row_wrap(7'(s_reg.wp) + 7'(ROWS - PRE));
    end
  end

  // Outputs
  assign avs_waitrequest = (avs_req.read | avs_req.write) & ~s_reg.ack;
  assign avs_readdata = s_reg.rdata;
  assign tx_valid = s_reg.txv;
  assign tx_data = s_reg.txd;
  assign nv_year_wr = s_reg.nvwr;
  assign nv_year_data = s_reg.date[23:16];
  assign alarm_contact = s_reg.alarm;
  assign front_panel_target_set = s_reg.tgt;
  assign access_level = s_reg.level;

endmodule // rem_core

// ---- tb/rem_core_chk.sv ----
// Assertion checker for the event, meter and command block
`timescale 1ns/1ns
module rem_core_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire rem_pkg::rem_avs_req_s avs_req,
  input wire logic avs_waitrequest,
  // Terminal stream
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  // Year store, panel and level
  input wire logic [7:0] nv_year_in,
  input wire logic nv_year_wr,
  input wire logic [7:0] nv_year_data,
  input wire logic alarm_contact,
  input wire logic front_panel_target_set,
  input wire logic [1:0] access_level
);
  import rem_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Any request pending
  logic req;
  // Access command taken at this edge
  logic take_acc;
  assign req = avs_req.read | avs_req.write;
  assign take_acc = avs_req.write & ~avs_waitrequest & (avs_req.address == REG_CMD)
    & (avs_req.writedata[3:0] == 4'h1);
  a_wait_one: assert property ($rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("waitrequest not low after one wait");
  a_tx_hold: assert property (
    tx_valid && !tx_ready && !(rx_valid && rx_char == CH_CAN) |=> tx_valid && $stable(tx_data))
    else $error("stream word dropped before taken");
  a_can_drop: assert property (
    tx_valid && rx_valid && rx_char == CH_CAN |=> !tx_valid)
    else $error("abort did not end stream");
  a_xoff_stop: assert property (
    (rx_valid && rx_char == CH_XOFF) ##1 tx_ready [*3] |=> !tx_valid)
    else $error("words sent while paused");
  a_year_alarm: assert property (nv_year_wr |-> ##[0:1] alarm_contact)
    else $error("year store without alarm");
  a_year_changed: assert property (nv_year_wr |-> nv_year_data != nv_year_in)
    else $error("unchanged year stored");
  a_alarm_long: assert property ($rose(alarm_contact) |-> alarm_contact [*8])
    else $error("alarm pulse too short");
  a_quit_level: assert property (
    front_panel_target_set |-> ##[0:1] access_level == 2'h0)
    else $error("quit left level raised");
  a_level_cause: assert property (
    $rose(access_level != 2'h0) |-> $past(take_acc) || $past(take_acc, 2))
    else $error("level rose without access command");
  // Main scenarios
  c_year: cover property (nv_year_wr);
  c_quit: cover property (front_panel_target_set);
  c_stall: cover property (tx_valid && !tx_ready);
endmodule // rem_core_chk

bind rem_core rem_core_chk u_chk (.clk, .rst, .avs_req, .avs_waitrequest, .tx_valid,
  .tx_data, .tx_ready, .rx_valid, .rx_char, .nv_year_in, .nv_year_wr, .nv_year_data,
  .alarm_contact, .front_panel_target_set, .access_level);

// ---- tb/rem_term.sv ----
// Terminal model: takes stream words, sends flow-control characters
`timescale 1ns/1ns
module rem_term (
  // Clock
  input wire logic clk,
  // Stream from the block
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  output logic tx_ready,
  // Characters to the block
  output logic rx_valid,
  output logic [7:0] rx_char
);
  // Words taken so far
  logic [31:0] words[$];
  // Slow mode stalls half the time
  logic slow;
  int cyc;
  initial
  begin
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_char = 8'h00;
    slow = 1'b0;
    cyc = 0;
  end
  // Take words and pace the ready line
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (tx_valid && tx_ready)
      words.push_back(tx_data);
    tx_ready <= !slow || cyc[1];
  end
  // One-cycle character; line shows the inverse afterwards
  task send(input logic [7:0] c);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_char <= c;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char <= ~c;
  endtask
endmodule // rem_term

// ---- tb/rem_core_bench.sv ----
// Self-checking bench for the event, meter and command block
`timescale 1ns/1ns
module rem_core_bench;
  import rem_pkg::*;
  logic clk = 0;
  logic rst = 1;
  rem_avs_req_s req = '0;
  logic avs_waitrequest, tx_valid, tx_ready, rx_valid, nv_wr, alarm, panel;
  logic [31:0] avs_readdata, tx_data, q, d, ha, hb;
  logic [7:0] rx_char, nv_year_data;
  logic [7:0] nv_year_in = 8'h01;
  rem_trigger_command_cause_s trigger_command_cause = '0;
  logic qc = 0, setc = 0, pwr = 0;
  logic [15:0] rowc = 16'h0100, trow;
  logic signed [6:0][15:0] meas = '0;
  logic [2:0] grp = 3'h2;
  rem_tc_s tc = '0;
  logic [1:0] level;
  int errors = 0, num_checks = 0, nyw = 0, npan = 0, n;
  int idx[3] = '{0, 12, 13};
  always #5 clk = ~clk;
  // Count year stores and panel pulses
  always @(posedge clk)
  begin
    nyw <= nyw + int'(nv_wr);
    npan <= npan + int'(panel);
  end
  rem_core #(.ID_WORD(32'h0000_1234)) u_rem_core (.clk, .rst, .avs_req(req), .avs_waitrequest,
    .avs_readdata, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_char, .trigger_command_cause_in(trigger_command_cause),
    .qc_strobe(qc), .sample_row(rowc), .meas, .fault_targets(8'ha5), .active_group(grp),
    .settings_changed(setc), .group_copied(1'b0), .power_lost(pwr), .tc_in(tc), .nv_year_in,
    .nv_year_wr(nv_wr), .nv_year_data, .alarm_contact(alarm), .front_panel_target_set(panel),
    .access_level(level));
  rem_term u_rem_term (.clk, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_char);
  // Compare and count
  task chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
    @(posedge clk);
    req <= '{a, !w, w, wd};
    // Sample waitrequest and read data at the rising edge, before the design updates
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    req <= '0;
  endtask
  task rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  // Poll status until not busy
  task idle;
    do bus(1'b0, REG_STAT, 32'h0); while (q[3] !== 1'b0);
  endtask
  task cmd(input rem_cmd_e c, input logic [7:0] arg);
    bus(1'b1, REG_CMD, {20'h0, arg, c});
    idle;
  endtask
  task res(input rem_res_e e);
    chk("result", 32'(q[7:4]), 32'(e));
  endtask
  task strobe(input int k);
    repeat (k)
    begin
      @(posedge clk);
      qc <= 1'b1;
      @(posedge clk);
      qc <= 1'b0;
      rowc <= rowc + 16'h1;
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    summarize;
  end
  initial
  begin
    meas[0] = 16'sd100;
    meas[1] = 16'sd300;
    meas[2] = 16'sd200;
    meas[5] = -16'sd50;
    hb = {2'b0, CAUSE_TRIP_VAR, 3'h3, 8'ha5, 16'd300};
    ha = {2'b0, CAUSE_CMD, 3'h2, 8'ha5, 16'd300};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc("date", REG_DATE, 32'h0001_0101);
    rdc("unmapped", 6'h30, 32'h0);
    cmd(CMD_METER, 8'h0);
    res(RES_BAD_LEVEL);
    cmd(CMD_NONE, 8'h0);
    res(RES_BAD_CMD);
    cmd(CMD_ACCESS, 8'h0);
    chk("level", 32'(level), 32'h1);
    $display("level test done");
    trow = rowc;
    cmd(CMD_TRIGGER, 8'h0);
    strobe(32);
    @(posedge clk);
    trigger_command_cause <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    grp <= 3'h3;
    @(posedge clk);
    trow = rowc;
    strobe(32);
    trigger_command_cause <= '0;
    bus(1'b1, REG_HSEL, 32'h1);
    rdc("newest", REG_HINFO, hb);
    bus(1'b1, REG_HSEL, 32'h2);
    rdc("older", REG_HINFO, ha);
    bus(1'b1, REG_DATA, 32'h0);
    bus(1'b1, REG_CMD, {28'h0, CMD_EVENT});
    wait (u_rem_term.words.size() >= 5);
    u_rem_term.send(CH_XOFF);
    n = u_rem_term.words.size();
    repeat (20) @(posedge clk);
    chk("paused", 32'(u_rem_term.words.size() <= n + 2), 32'h1);
    u_rem_term.send(CH_XON);
    idle;
    chk("length", 32'(u_rem_term.words.size()), 32'd47);
    chk("head", u_rem_term.words[0], hb);
    chk("trigrow", u_rem_term.words[18], {16'h0, trow});
    u_rem_term.words.delete();
    bus(1'b1, REG_DATA, 32'h2);
    bus(1'b1, REG_CMD, {28'h0, CMD_EVENT});
    wait (u_rem_term.words.size() >= 3);
    u_rem_term.send(CH_CAN);
    idle;
    chk("aborted", 32'(u_rem_term.words.size() < 47), 32'h1);
    $display("event test done");
    u_rem_term.words.delete();
    u_rem_term.slow = 1'b1;
    cmd(CMD_METER, 8'h2);
    u_rem_term.slow = 1'b0;
    chk("repeats", 32'(u_rem_term.words.size()), 32'd14);
    chk("power", u_rem_term.words[12], 32'hffff_ffce);
    meas[0] <= 16'sd0;
    strobe(16);
    bus(1'b1, REG_QSEL, 32'h0);
    bus(1'b0, REG_DEM, 32'h0);
    d = q;
    cmd(CMD_PEAK_RST, CH_YES);
    rdc("peak", REG_PEAK, d);
    cmd(CMD_DEM_RST, 8'h58);
    res(RES_NOT_CONFIRMED);
    rdc("demand", REG_DEM, d);
    cmd(CMD_DEM_RST, CH_YES);
    rdc("demand", REG_DEM, 32'h0);
    rdc("peak", REG_PEAK, d);
    bus(1'b1, REG_CFG, 32'h1);
    meas[0] <= 16'sd100;
    strobe(8);
    grp <= 3'h1;
    repeat (4) @(posedge clk);
    rdc("demand", REG_DEM, 32'h0);
    rdc("kept", REG_HINFO, ha);
    $display("meter test done");
    setc <= 1'b1;
    @(posedge clk);
    setc <= 1'b0;
    repeat (3) @(posedge clk);
    rdc("cleared", REG_HINFO, 32'h0);
    foreach (idx[i])
    begin
      bus(1'b1, REG_DATA, 32'(idx[i]));
      cmd(CMD_EVENT, 8'h0);
      res(RES_BAD_EVENT);
    end
    bus(1'b0, REG_DATE, 32'h0);
    d = q;
    cmd(CMD_TSYNC, 8'h0);
    res(RES_TC_ERROR);
    rdc("date", REG_DATE, d);
    tc <= '{1'b1, 1'b1, 24'h070605, 32'h10};
    u_rem_term.words.delete();
    cmd(CMD_TSYNC, 8'h0);
    rdc("date", REG_DATE, 32'h0007_0605);
    chk("id", u_rem_term.words[0], 32'h0000_1234);
    u_rem_term.words.delete();
    bus(1'b1, REG_DATA, 32'h005d_0501);
    cmd(CMD_DATE, 8'h0);
    chk("stores", 32'(nyw), 32'h1);
    chk("echo", u_rem_term.words[0], 32'h005d_0501);
    nv_year_in <= 8'h5d;
    bus(1'b1, REG_DATA, 32'h005d_0602);
    cmd(CMD_DATE, 8'h0);
    chk("stores", 32'(nyw), 32'h1);
    $display("clock test done");
    u_rem_term.words.delete();
    cmd(CMD_QUIT, 8'h0);
    chk("level", 32'(level), 32'h0);
    chk("panel", 32'(npan), 32'h1);
    chk("id", u_rem_term.words[0], 32'h0000_1234);
    pwr <= 1'b1;
    repeat (4) @(posedge clk);
    pwr <= 1'b0;
    repeat (6) @(posedge clk);
    rdc("demand", REG_DEM, 32'h0);
    rdc("peak", REG_PEAK, 32'h0);
    $display("quit test done");
    summarize;
  end
endmodule // rem_core_bench
